/* hw/gpc_pkg.sv */
/*
 * Shared constants for the pad controller: register offsets
 * inside one group window, field positions, reset values and
 * the on-demand sampling delay.
 * Assumes byte addresses on a 32-bit word bus.
 */
package gpc_pkg;

    // Geometry
    localparam int GPC_PADS       = 32;
    localparam int GPC_OCTET      = 8;
    localparam int GPC_NFUNC      = 16;
    localparam int GPC_GRP_STRIDE = 'h80;

    // Offsets inside a group window
    localparam logic [6:0] OFS_OE      = 7'h00;
    localparam logic [6:0] OFS_OE_CLR  = 7'h04;
    localparam logic [6:0] OFS_OE_SET  = 7'h08;
    localparam logic [6:0] OFS_OE_TGL  = 7'h0c;
    localparam logic [6:0] OFS_DL      = 7'h10;
    localparam logic [6:0] OFS_DL_CLR  = 7'h14;
    localparam logic [6:0] OFS_DL_SET  = 7'h18;
    localparam logic [6:0] OFS_DL_TGL  = 7'h1c;
    localparam logic [6:0] OFS_SAMP    = 7'h20;
    localparam logic [6:0] OFS_CTRL    = 7'h24;
    localparam logic [6:0] OFS_FSEL    = 7'h30;
    localparam logic [6:0] OFS_CFG     = 7'h40;

    // Per-pad config byte fields
    localparam int CFG_ROUTE = 0;
    localparam int CFG_RX    = 1;
    localparam int CFG_PULL  = 2;

    // Reset values
    localparam logic [31:0] RST_OE   = 32'h0000_0000;
    localparam logic [31:0] RST_DL   = 32'h0000_0000;
    localparam logic [3:0]  RST_CTRL = 4'h0;
    localparam logic [2:0]  RST_CFG  = 3'h0;
    localparam logic [3:0]  RST_FSEL = 4'h0;

    // Synchroniser depth, also the on-demand read delay
    localparam logic [1:0]  DEMAND_DLY = 2'h2;

    // Write kinds selected by offset bits 3:2
    typedef enum logic [1:0] {
        GPC_WOP_WR,
        GPC_WOP_CLR,
        GPC_WOP_SET,
        GPC_WOP_TGL
    } gpc_wop_t;

endpackage

/* hw/gpc_sync_if.sv */
/*
 * Carrier between the controller core and one group's input
 * synchroniser. Assumes both ends share the controller clock.
 */
`timescale 1ns/1ps
interface gpc_sync_if;
    logic [31:0] pad_lvl;   // Raw pad levels
    logic [31:0] samp_en;   // Per-pad synchroniser clock enable
    logic [31:0] sampled;   // Resynchronised levels

    modport ctl (output pad_lvl, output samp_en, input sampled);
    modport syn (input pad_lvl, input samp_en, output sampled);
endinterface

/* hw/gpc_sync.sv */
/*
 * Two-stage input synchroniser for one pad group with a per-pad
 * enable, so idle pads burn no clock power in the flops.
 * Assumes pad levels may change at any time.
 */
`timescale 1ns/1ps
module gpc_sync
    import gpc_pkg::*;
(
    input  wire logic   clk_sys_in,  // Controller clock
    input  wire logic   arst_n_in,   // Async reset, active low
    gpc_sync_if.syn     s            // Core side
);
    logic [31:0] stg1_ff;
    logic [31:0] stg2_ff;

    // Both stages advance only where enabled
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stg1_ff <= '0;
            stg2_ff <= '0;
        end else begin
            stg1_ff <= (stg1_ff & ~s.samp_en) | (s.pad_lvl & s.samp_en);
            stg2_ff <= (stg2_ff & ~s.samp_en) | (stg1_ff & s.samp_en);
        end
    end

    assign s.sampled = stg2_ff;

    AST_SYNC_HOLD: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (s.samp_en == 32'h0000_0000) |=> $stable(s.sampled))
        else $error("sampled level moved while sampling off");

    AST_SYNC_TWO: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        s.samp_en[0] [*2] |=> (s.sampled[0] == $past(s.pad_lvl[0], 2)))
        else $error("sampled level not two cycles behind pad");
endmodule

/* hw/gpc_top.sv */
/*
 * Pad controller top: per-group output enable and drive level
 * with write/clear/set/toggle, sampled level, sampling control,
 * per-pad config bytes and function selectors, pad muxing.
 * Assumes an APB master and a single-cycle local bus master,
 * both synchronous to clk_sys_in; pad inputs asynchronous.
 */
// Design decisions made here: the APB register port and the register offsets.
// Functional notes
// - One register set per group of up to 32 pads, one bit per pad.
// - Group g register window starts at base plus 0x80 times g.
// - Output enable bit 1 makes the pad an output, 0 an input.
// - An output pad is driven to its drive level bit.
// - Ones written to set/clear registers set/clear enable bits only there.
// - Ones written to level set/clear/toggle change only those bits.
// - Pad levels reach the sampled register through a synchroniser.
// - A pad with receiver off is not sampled.
// - On-demand sampling runs only for a read, which waits two cycles.
// - One continuous sampling bit per eight pads removes the wait; here the wait goes only with all four bits set.
// - Route enable hands the pad to the selected peripheral signal.
// - Four-bit selector per pad, sixteen signals, byte at pad/2.
// - One config byte per pad at config base plus pad number.
// - Reset leaves pads tri-stated, receivers off, general logic attached.
// - Enable, receiver and pull all off disables the pad entirely.
// - Pull on an input pad follows the drive level bit.
// - An enabled output driver forces pull off.
// - Local bus is served before APB when both access.
// - APB access may be stalled by a cycle on a collision.
`timescale 1ns/1ps
module gpc_top
    import gpc_pkg::*;
#(
    parameter int NUM_GROUPS = 2
) (
    input  wire logic                           clk_sys_in,      // Controller clock
    input  wire logic                           arst_n_in,       // Async reset, active low
    input  wire logic                           psel_in,         // APB select
    input  wire logic                           penable_in,      // APB enable
    input  wire logic                           pwrite_in,       // APB direction
    input  wire logic [11:0]                    paddr_in,        // APB byte address
    input  wire logic [31:0]                    pwdata_in,       // APB write data
    input  wire logic [3:0]                     pstrb_in,        // APB byte strobes
    output logic      [31:0]                    prdata_out,      // APB read data
    output logic                                pready_out,      // APB ready
    output logic                                pslverr_out,     // APB error
    input  wire logic                           lb_sel_in,       // Local bus access
    input  wire logic                           lb_write_in,     // Local bus write
    input  wire logic [11:0]                    lb_addr_in,      // Local bus address
    input  wire logic [31:0]                    lb_wdata_in,     // Local bus data
    input  wire logic [3:0]                     lb_be_in,        // Local bus byte enables
    output logic      [31:0]                    lb_rdata_out,    // Local bus read data
    input  wire logic [NUM_GROUPS-1:0][31:0]    pad_in,          // Pad levels
    output logic      [NUM_GROUPS-1:0][31:0]    pad_out,         // Pad drive value
    output logic      [NUM_GROUPS-1:0][31:0]    pad_oe_out,      // Pad driver on
    output logic      [NUM_GROUPS-1:0][31:0]    pad_rx_en_out,   // Pad receiver on
    output logic      [NUM_GROUPS-1:0][31:0]    pad_pull_en_out, // Pad pull on
    output logic      [NUM_GROUPS-1:0][31:0]    pad_pull_up_out, // Pull up, else down
    input  wire logic [NUM_GROUPS-1:0][31:0][15:0] periph_do_in, // Peripheral drive
    input  wire logic [NUM_GROUPS-1:0][31:0][15:0] periph_oe_in, // Peripheral enable
    output logic      [NUM_GROUPS-1:0][31:0]    periph_di_out    // Pad level to peripheral
);
    localparam int NG = NUM_GROUPS;

    if (NUM_GROUPS < 1 || NUM_GROUPS > 32) begin : g_chk
        $error("NUM_GROUPS must be 1 to 32");
    end

    // Register state, one copy per group; local bus read data and demand counter shared
    logic [31:0] oe_ff   [NG];
    logic [31:0] dl_ff   [NG];
    logic [3:0]  ctrl_ff [NG];
    logic [2:0]  cfg_ff  [NG][GPC_PADS];
    logic [3:0]  fsel_ff [NG][GPC_PADS];
    logic [31:0] samp_w  [NG];
    logic [31:0] lb_rdata_ff;
    logic [1:0]  dem_cnt_ff;
    logic [NG-1:0][31:0] periph_di_ff;

    // Byte lanes or sampling octets to a bit mask
    function automatic logic [31:0] oct_mask(input logic [3:0] b);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[GPC_OCTET*i +: GPC_OCTET] = {GPC_OCTET{b[i]}};
        end
        return m;
    endfunction

    // Bitwise update shared by both buses
    function automatic logic [31:0] apply_wop(input logic [31:0] cur,
                                              input logic [31:0] wd,
                                              input logic [31:0] msk,
                                              input gpc_wop_t    op);
        logic [31:0] v;
        v = wd & msk;
        unique case (op)
            GPC_WOP_WR:  return (cur & ~msk) | v;
            GPC_WOP_CLR: return cur & ~v;
            GPC_WOP_SET: return cur | v;
            GPC_WOP_TGL: return cur ^ v;
        endcase
    endfunction

    // Offset is backed by a register
    function automatic logic ofs_ok(input logic [6:0] o);
        return (o[6:5] == 2'h0) || (o == OFS_SAMP) || (o == OFS_CTRL)
            || (o[6:4] == OFS_FSEL[6:4] && o[3:2] != 2'h3 ? 1'b0 : 1'b0)
            || (o[6:4] == OFS_FSEL[6:4]) || (o[6:5] == OFS_CFG[6:5]);
    endfunction

    // Read view, shared by both buses; set/clear/toggle show the base
    function automatic logic [31:0] rd_reg(input int g, input logic [6:0] o);
        logic [31:0] r;
        int          w;
        r = '0;
        w = 0;
        if (o[6:5] == 2'h0) begin
            r = o[4] ? dl_ff[g] : oe_ff[g];
        end else if (o == OFS_SAMP) begin
            r = samp_w[g];
        end else if (o == OFS_CTRL) begin
            r = {28'h0, ctrl_ff[g]};
        end else if (o[6:4] == OFS_FSEL[6:4]) begin
            w = int'(o[3:2]) * 8;
            for (int k = 0; k < 4; k++) begin
                r[8*k +: 8] = {fsel_ff[g][w+2*k+1], fsel_ff[g][w+2*k]};
            end
        end else if (o[6:5] == OFS_CFG[6:5]) begin
            w = int'(o[4:2]) * 4;
            for (int k = 0; k < 4; k++) begin
                r[8*k +: 8] = {5'h0, cfg_ff[g][w+k]};
            end
        end
        return r;
    endfunction

    // Bus decode: group from bits 11:7, window offset 6:0
    logic [4:0] a_grp;
    logic [6:0] a_ofs;
    logic [4:0] l_grp;
    logic [6:0] l_ofs;
    logic       a_gok;
    logic       l_gok;
    logic       apb_acc;
    logic       apb_wr;
    logic       lb_wr;
    logic       in_rd;
    logic       need_dly;

    assign a_grp   = paddr_in[11:7];
    assign a_ofs   = paddr_in[6:0];
    assign l_grp   = lb_addr_in[11:7];
    assign l_ofs   = lb_addr_in[6:0];
    assign a_gok   = int'(a_grp) < NG;
    assign l_gok   = int'(l_grp) < NG;
    assign apb_acc = psel_in & penable_in;
    assign apb_wr  = pready_out & pwrite_in & a_gok;
    assign lb_wr   = lb_sel_in & lb_write_in & l_gok;
    assign in_rd   = apb_acc & ~pwrite_in & a_gok & (a_ofs == OFS_SAMP);

    // Any octet without continuous sampling needs the demand path
    always_comb begin
        need_dly = 1'b0;
        for (int g = 0; g < NG; g++) begin
            if (int'(a_grp) == g && ctrl_ff[g] != 4'hf) begin
                need_dly = in_rd;
            end
        end
    end

    // Demand wait counter, cleared between transfers
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dem_cnt_ff <= 2'h0;
        end else if (!apb_acc || pready_out) begin
            dem_cnt_ff <= 2'h0;
        end else if (need_dly && dem_cnt_ff != DEMAND_DLY) begin
            dem_cnt_ff <= dem_cnt_ff + 2'h1;
        end
    end

    // Local bus never waits, so APB yields to it
    assign pready_out  = apb_acc & ~lb_sel_in
                       & (~need_dly | dem_cnt_ff == DEMAND_DLY);
    assign pslverr_out = pready_out & ~(a_gok & ofs_ok(a_ofs));

    // APB read data straight from the register view
    always_comb begin
        prdata_out = 32'h0000_0000;
        if (apb_acc && !pwrite_in && a_gok && ofs_ok(a_ofs)) begin
            prdata_out = rd_reg(int'(a_grp), a_ofs);
        end
    end

    // Local bus reads: enable/level family and sampled level only
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lb_rdata_ff <= 32'h0000_0000;
        end else if (lb_sel_in && !lb_write_in && l_gok
                     && (l_ofs[6:5] == 2'h0 || l_ofs == OFS_SAMP)) begin
            lb_rdata_ff <= rd_reg(int'(l_grp), l_ofs);
        end else begin
            lb_rdata_ff <= 32'h0000_0000;
        end
    end
    assign lb_rdata_out = lb_rdata_ff;

    // Per-group register files
    for (genvar g = 0; g < NG; g++) begin : g_grp
        gpc_sync_if sif ();

        // Output enable: local bus has the port when both write
        always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                oe_ff[g] <= RST_OE;
            end else if (lb_wr && int'(l_grp) == g && l_ofs[6:4] == 3'h0) begin
                oe_ff[g] <= apply_wop(oe_ff[g], lb_wdata_in, oct_mask(lb_be_in),
                                      gpc_wop_t'(l_ofs[3:2]));
            end else if (apb_wr && int'(a_grp) == g && a_ofs[6:4] == 3'h0) begin
                oe_ff[g] <= apply_wop(oe_ff[g], pwdata_in, oct_mask(pstrb_in),
                                      gpc_wop_t'(a_ofs[3:2]));
            end
        end

        // Drive level, same write kinds
        always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                dl_ff[g] <= RST_DL;
            end else if (lb_wr && int'(l_grp) == g && l_ofs[6:4] == 3'h1) begin
                dl_ff[g] <= apply_wop(dl_ff[g], lb_wdata_in, oct_mask(lb_be_in),
                                      gpc_wop_t'(l_ofs[3:2]));
            end else if (apb_wr && int'(a_grp) == g && a_ofs[6:4] == 3'h1) begin
                dl_ff[g] <= apply_wop(dl_ff[g], pwdata_in, oct_mask(pstrb_in),
                                      gpc_wop_t'(a_ofs[3:2]));
            end
        end

        // Sampling control, APB only
        always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                ctrl_ff[g] <= RST_CTRL;
            end else if (apb_wr && int'(a_grp) == g && a_ofs == OFS_CTRL && pstrb_in[0]) begin
                ctrl_ff[g] <= pwdata_in[3:0];
            end
        end

        // Config bytes and selector nibbles, byte-writable
        always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                for (int p = 0; p < GPC_PADS; p++) begin
                    cfg_ff[g][p]  <= RST_CFG;
                    fsel_ff[g][p] <= RST_FSEL;
                end
            end else if (apb_wr && int'(a_grp) == g) begin
                for (int p = 0; p < GPC_PADS; p++) begin
                    if (a_ofs[6:2] == 5'((int'(OFS_CFG) + p) >> 2) && pstrb_in[p%4]) begin
                        cfg_ff[g][p] <= pwdata_in[8*(p%4) +: 3];
                    end
                    if (a_ofs[6:2] == 5'((int'(OFS_FSEL) + p/2) >> 2) && pstrb_in[(p/2)%4]) begin
                        fsel_ff[g][p] <= pwdata_in[8*((p/2)%4) + 4*(p%2) +: 4];
                    end
                end
            end
        end

        // Synchroniser feed: continuous octets, or a pending demand read
        logic dem_g;
        logic [31:0] rx_g;
        assign dem_g = in_rd && int'(a_grp) == g && dem_cnt_ff != DEMAND_DLY
                       && !pready_out;
        always_comb begin
            for (int p = 0; p < GPC_PADS; p++) begin
                rx_g[p] = pad_rx_en_out[g][p];
            end
        end
        assign sif.pad_lvl = pad_in[g];
        assign sif.samp_en = rx_g & (oct_mask(ctrl_ff[g]) | {32{dem_g}});
        assign samp_w[g]   = sif.sampled;

        gpc_sync u_sync (
            .clk_sys_in (clk_sys_in),
            .arst_n_in  (arst_n_in),
            .s          (sif.syn)
        );

        // Pad mux: peripheral takes the whole pad when routed
        always_comb begin
            for (int p = 0; p < GPC_PADS; p++) begin
                if (cfg_ff[g][p][CFG_ROUTE]) begin
                    pad_out[g][p]         = periph_do_in[g][p][fsel_ff[g][p]];
                    pad_oe_out[g][p]      = periph_oe_in[g][p][fsel_ff[g][p]];
                    pad_rx_en_out[g][p]   = 1'b1;
                    pad_pull_en_out[g][p] = 1'b0;
                    pad_pull_up_out[g][p] = 1'b0;
                end else begin
                    pad_oe_out[g][p]      = oe_ff[g][p];
                    pad_out[g][p]         = oe_ff[g][p] & dl_ff[g][p];
                    pad_rx_en_out[g][p]   = cfg_ff[g][p][CFG_RX];
                    pad_pull_en_out[g][p] = cfg_ff[g][p][CFG_PULL] & ~oe_ff[g][p];
                    pad_pull_up_out[g][p] = cfg_ff[g][p][CFG_PULL] & ~oe_ff[g][p]
                                          & dl_ff[g][p];
                end
            end
        end

        // Pad level to peripherals, held low when not routed
        always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                periph_di_ff[g] <= 32'h0000_0000;
            end else begin
                for (int p = 0; p < GPC_PADS; p++) begin
                    periph_di_ff[g][p] <= pad_in[g][p] & cfg_ff[g][p][CFG_ROUTE];
                end
            end
        end
    end
    assign periph_di_out = periph_di_ff;

    // Checks; register and pad checks on group 0, bus timing checks on any group
    logic [31:0] route0;
    always_comb begin
        for (int p = 0; p < GPC_PADS; p++) begin
            route0[p] = cfg_ff[0][p][CFG_ROUTE];
        end
    end

    sequence s_apb_g0_wr(logic [6:0] o);
        pready_out && pwrite_in && a_grp == 5'h0 && a_ofs == o
        && pstrb_in == 4'hf && !lb_sel_in;
    endsequence

    sequence s_collide;
        apb_acc && lb_sel_in && !need_dly;
    endsequence

    AST_OE_SET: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        s_apb_g0_wr(OFS_OE_SET) |=> oe_ff[0] == ($past(oe_ff[0]) | $past(pwdata_in)))
        else $error("enable set changed wrong bits");

    AST_DL_TGL: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        s_apb_g0_wr(OFS_DL_TGL) |=> dl_ff[0] == ($past(dl_ff[0]) ^ $past(pwdata_in)))
        else $error("level toggle changed wrong bits");

    AST_DRIVE: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ((pad_out[0] ^ (dl_ff[0] & oe_ff[0])) & ~route0) == 32'h0000_0000)
        else $error("output pad not at drive level");

    AST_PULL_OFF: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (pad_pull_en_out[0] & pad_oe_out[0]) == 32'h0000_0000)
        else $error("pull left on with driver on");

    AST_DEMAND: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (need_dly && dem_cnt_ff == 2'h0) |-> !pready_out ##1 !pready_out)
        else $error("demand read finished early");

    AST_NO_WAIT: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (in_rd && !need_dly && !lb_sel_in) |-> pready_out)
        else $error("continuous read delayed");

    AST_LB_FIRST: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        lb_sel_in |-> !pready_out)
        else $error("APB served during local access");

    AST_STALL_ONE: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        s_collide ##1 (!lb_sel_in && apb_acc) |-> pready_out)
        else $error("APB stalled past the collision");

    AST_LB_READ: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (lb_sel_in && !lb_write_in && l_grp == 5'h0 && l_ofs == OFS_OE_CLR)
        |=> lb_rdata_out == $past(oe_ff[0]))
        else $error("clear register did not read back enable");
endmodule

/* testbench/gpc_pad_model.sv */
/*
 * Pad environment seen from the controller pins: resolves each
 * pad from the controller driver, its pull, or an outside level.
 * Assumes the bench sets the outside level on undriven pads.
 */
`timescale 1ns/1ps
module gpc_pad_model #(
    parameter int NG = 2
) (
    input  wire logic [NG-1:0][31:0] pad_out_in,  // Controller drive value
    input  wire logic [NG-1:0][31:0] pad_oe_in,   // Controller driver on
    input  wire logic [NG-1:0][31:0] pull_en_in,  // Pull on
    input  wire logic [NG-1:0][31:0] pull_up_in,  // Pull direction
    input  wire logic [NG-1:0][31:0] ext_in,      // Outside level when undriven
    output logic      [NG-1:0][31:0] pad_lvl_out  // Resolved pad level
);
    // Driver beats pull, pull beats the outside world
    assign pad_lvl_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & pull_en_in & pull_up_in)
                       | (~pad_oe_in & ~pull_en_in & ext_in);
endmodule

/* testbench/gpio_pad_controller_tb_top.sv */
/*
 * Self-checking bench for the pad controller: APB register
 * table walk, pad pins, sampling delay, bus collision, routing.
 * Assumes the pad model closes the loop on pad_in.
 */
`timescale 1ns/1ps
module gpio_pad_controller_tb_top;
    import gpc_pkg::*;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d;} gpc_row_t;
    logic clk_sys_in, arst_n_in, psel, penable, pwrite, lb_sel, lb_write, pready, pslverr;
    logic [11:0] paddr, lb_addr;
    logic [31:0] pwdata, lb_wdata, prdata, lb_rdata, rd;
    logic [1:0][31:0] pad_in, pad_out, oe, rx, pen, pup, di, ext;
    logic [1:0][31:0][15:0] pdo, poe;
    logic err;
    int n, miscompares, n_checks, cyc;
    gpc_row_t rows[18] = '{'{0,12'h000,32'h0}, '{1,12'h008,32'hf}, '{1,12'h004,32'h3},
        '{0,12'h00c,32'hc}, '{1,12'h018,32'hf0}, '{1,12'h014,32'h30}, '{1,12'h01c,32'h105},
        '{0,12'h010,32'h1c5}, '{1,12'h088,32'h1}, '{0,12'h080,32'h1}, '{0,12'h000,32'hc},
        '{1,12'h040,32'h402}, '{1,12'h030,32'ha5}, '{0,12'h030,32'ha5}, '{0,12'h040,32'h402},
        '{0,12'h024,32'h0}, '{1,12'h080,32'h6}, '{0,12'h084,32'h6}};

    gpc_top #(.NUM_GROUPS(2)) dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(4'hf), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .lb_sel_in(lb_sel), .lb_write_in(lb_write), .lb_addr_in(lb_addr), .lb_wdata_in(lb_wdata),
        .lb_be_in(4'hf), .lb_rdata_out(lb_rdata), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_out(oe), .pad_rx_en_out(rx), .pad_pull_en_out(pen), .pad_pull_up_out(pup),
        .periph_do_in(pdo), .periph_oe_in(poe), .periph_di_out(di));
    gpc_pad_model #(.NG(2)) pads (.pad_out_in(pad_out), .pad_oe_in(oe), .pull_en_in(pen),
        .pull_up_in(pup), .ext_in(ext), .pad_lvl_out(pad_in));

    // Free-running clock, 40 ns
    initial begin
        clk_sys_in = 0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; n counts access cycles until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    // Hang guard, far above the hundred or so cycles used
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        {psel, penable, pwrite, lb_sel, lb_write} = '0;
        {paddr, lb_addr, pwdata, lb_wdata} = '0;
        ext = '0; pdo = '0; poe = '1;
        arst_n_in = 0;
        repeat (2) @(posedge clk_sys_in);
        arst_n_in <= 1;
        // Register table walk
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check("reg", rd, rows[i].d);
        end
        #1;
        check("oe", oe[0], 32'hc);
        check("drive", pad_out[0] & 32'hc, 32'h4);
        check("pull_en", pen[0] & 32'h3, 32'h2);
        check("pull_up", pup[0] & 32'h2, 32'h0);
        check("rx", rx[0] & 32'h3, 32'h1);
        // Receiver enabled on pad 0 first; demand read waits two cycles
        ext <= '1;
        apb(0, 12'h020, 32'h0);
        check("demand_wait", n, 3);
        check("sampled", rd, 32'h1);
        apb(1, 12'h024, 32'hf);
        apb(0, 12'h020, 32'h0);
        check("cont_wait", n, 1);
        // Local bus set then read back; pad 1 becomes output
        @(posedge clk_sys_in);
        lb_sel <= 1; lb_write <= 1; lb_addr <= 12'h008; lb_wdata <= 32'h2;
        @(posedge clk_sys_in);
        lb_write <= 0; lb_addr <= 12'h004;
        @(posedge clk_sys_in);
        lb_addr <= 12'h020;
        #1;
        check("lb_rd", lb_rdata, 32'he);
        @(posedge clk_sys_in);
        lb_sel <= 0;
        #1;
        check("lb_samp", lb_rdata, 32'h1);
        check("pull_off", pen[0] & 32'h2, 32'h0);
        // Collision: local bus holds the first access cycle
        fork
            apb(0, 12'h010, 32'h0);
            begin
                repeat (2) @(posedge clk_sys_in);
                lb_sel <= 1;
                @(posedge clk_sys_in);
                lb_sel <= 0;
            end
        join
        check("stall", n, 2);
        check("stall_rd", rd, 32'h1c5);
        // Routing pad 0 to function 5, then 4
        pdo[0][0] <= 16'h0020;
        apb(1, 12'h040, 32'h403);
        #1;
        check("route", {30'h0, oe[0][0], pad_out[0][0]}, 32'h3);
        apb(1, 12'h030, 32'ha4);
        #1;
        check("route_sel", {31'h0, pad_out[0][0]}, 32'h0);
        check("route_in", di[0] & 32'h3, 32'h1);
        // Unmapped offset and absent group
        apb(0, 12'h02c, 32'h0);
        check("err_ofs", {31'h0, err}, 32'h1);
        apb(0, 12'h100, 32'h0);
        check("err_grp", {31'h0, err}, 32'h1);
        // Reset in mid-run clears everything with no edge
        arst_n_in <= 0;
        #5;
        check("rst_oe", oe[0] | pen[0] | rx[0] | pad_out[0] | di[0], 32'h0);
        @(posedge clk_sys_in);
        arst_n_in <= 1;
        apb(0, 12'h010, 32'h0);
        check("rst_dl", rd, 32'h0);
        close_out();
    end
endmodule
